// ==== hw/wdts_top.sv ====
// Seconds watchdog with interval and event-select I/O ports.
// Assumes port writes are synchronous single-cycle strobes on clk_sys_i.
`timescale 1ns/1ps
module wdts_top #(
	parameter int TICK_CYCLES = wdts_pkg::WDTS_TICK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic io_wr_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	output wdts_pkg::wdts_event_t event_o,
	output logic running_o,
	output logic [7:0] count_o
);
	import wdts_pkg::*;

	// Core registers and the tick strobe
	logic [7:0] count_q;
	logic [7:0] evsel_q;
	logic [31:0] tick_cnt_q;
	logic tick;
	wdts_state_t state_q;
	// Decoded strobes
	logic wr_interval;
	logic wr_event;
	logic wr_start;
	logic wr_stop;
	logic expire;
	logic fire;
	wdts_event_t fire_sel;
	// One flop per event line
	logic sys_reset_q;
	logic irq10_q;
	logic irq15_q;
	logic irq11_q;
	logic nmi_q;

	// Port address match
	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ref_a);
		addr_hit = (a == ref_a);
	endfunction

	// Countdown is live
	function automatic logic is_running(input wdts_state_t st);
		is_running = (st == WDTS_RUN);
	endfunction

	// Event code to event lines, undefined codes select none
	function automatic wdts_event_t ev_decode(input logic [7:0] code);
		wdts_event_t ev;
		ev = '0;
		case (code)
			WDTS_EVENT_RESET: ev.sys_reset = 1'b1;
			WDTS_EVENT_IRQ10: ev.irq10 = 1'b1;
			WDTS_EVENT_IRQ15: ev.irq15 = 1'b1;
			WDTS_EVENT_IRQ11: ev.irq11 = 1'b1;
			WDTS_EVENT_NMI: ev.nmi = 1'b1;
			default: ev = '0;
		endcase
		ev_decode = ev;
	endfunction

	// Port write decode
	assign wr_interval = io_wr_i && addr_hit(io_addr_i, WDTS_ADDR_INTERVAL);
	assign wr_event = io_wr_i && addr_hit(io_addr_i, WDTS_ADDR_EVENT);
	assign wr_start = wr_interval && (io_wdata_i != 8'h00);
	assign wr_stop = wr_interval && (io_wdata_i == 8'h00);

	// Second boundary and expiry
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
	assign expire = is_running(state_q) && tick && (count_q == 8'h01);

	// An interval write in the fire cycle takes precedence and cancels the pulse
	assign fire = (state_q == WDTS_FIRE) && !wr_interval;
	assign fire_sel = ev_decode(evsel_q);

	// Event select register
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			evsel_q <= WDTS_EVENT_RST_VAL;
		end else if (wr_event) begin
			evsel_q <= io_wdata_i;
		end
	end

	// One-second prescaler, realigned on every interval write so the first second is full
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt_q <= 32'h0000_0000;
		end else if (wr_interval || tick || !is_running(state_q)) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	// Countdown state
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= WDTS_IDLE;
		end else if (wr_stop) begin
			state_q <= WDTS_IDLE;
		end else if (wr_start) begin
			state_q <= WDTS_RUN;
		end else begin
			case (state_q)
				WDTS_RUN: begin
					if (expire) begin
						state_q <= WDTS_FIRE;
					end
				end
				WDTS_FIRE: begin
					state_q <= WDTS_IDLE;
				end
				default: begin
					state_q <= WDTS_IDLE;
				end
			endcase
		end
	end

	// Remaining seconds, a write beats a tick in the same cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_q <= WDTS_INTERVAL_RST_VAL;
		end else if (wr_interval) begin
			count_q <= io_wdata_i;
		end else if (is_running(state_q) && tick) begin
			count_q <= count_q - 8'h01;
		end
	end

	// System reset request, one cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys_reset_q <= 1'b0;
		end else if (fire && fire_sel.sys_reset) begin
			sys_reset_q <= 1'b1;
		end else begin
			sys_reset_q <= 1'b0;
		end
	end

	// First interrupt line, one cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq10_q <= 1'b0;
		end else if (fire && fire_sel.irq10) begin
			irq10_q <= 1'b1;
		end else begin
			irq10_q <= 1'b0;
		end
	end

	// Second interrupt line, one cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq15_q <= 1'b0;
		end else if (fire && fire_sel.irq15) begin
			irq15_q <= 1'b1;
		end else begin
			irq15_q <= 1'b0;
		end
	end

	// Third interrupt line, one cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq11_q <= 1'b0;
		end else if (fire && fire_sel.irq11) begin
			irq11_q <= 1'b1;
		end else begin
			irq11_q <= 1'b0;
		end
	end

	// Non-maskable interrupt, one cycle
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nmi_q <= 1'b0;
		end else if (fire && fire_sel.nmi) begin
			nmi_q <= 1'b1;
		end else begin
			nmi_q <= 1'b0;
		end
	end

	// Running flag
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			running_o <= 1'b0;
		end else begin
			running_o <= is_running(state_q);
		end
	end

	// Remaining seconds shown to the host
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_o <= 8'h00;
		end else begin
			count_o <= count_q;
		end
	end

	// Event lines in struct order, each straight from its flop
	assign event_o = {sys_reset_q, irq10_q, irq15_q, irq11_q, nmi_q};
endmodule

// ==== inc/wdts_pkg.sv ====
// Package for the seconds watchdog: port addresses, event codes, timing.
// Assumes a 50 MHz system clock and a byte-wide I/O port write interface.
package wdts_pkg;
	localparam logic [15:0] WDTS_ADDR_INTERVAL = 16'h0443;
	localparam logic [15:0] WDTS_ADDR_EVENT = 16'h0444;
	localparam logic [7:0] WDTS_EVENT_RESET = 8'h00;
	localparam logic [7:0] WDTS_EVENT_IRQ10 = 8'h01;
	localparam logic [7:0] WDTS_EVENT_IRQ15 = 8'h02;
	localparam logic [7:0] WDTS_EVENT_IRQ11 = 8'h03;
	localparam logic [7:0] WDTS_EVENT_NMI = 8'h04;
	localparam logic [7:0] WDTS_EVENT_RST_VAL = WDTS_EVENT_RESET;
	localparam logic [7:0] WDTS_INTERVAL_RST_VAL = 8'h00;
	localparam int WDTS_CLK_HZ = 50000000;
	localparam int WDTS_TICK_S = 1;
	localparam int WDTS_TICK_CYCLES = WDTS_CLK_HZ * WDTS_TICK_S;
	localparam int WDTS_PULSE_CYCLES = 1;

	typedef struct packed {
		logic sys_reset;
		logic irq10;
		logic irq15;
		logic irq11;
		logic nmi;
	} wdts_event_t;

	typedef enum logic [1:0] {
		WDTS_IDLE = 2'b00,
		WDTS_RUN = 2'b01,
		WDTS_FIRE = 2'b11
	} wdts_state_t;
endpackage

// ==== tb/wdts_assertions.sv ====
// Checker for watchdog load, countdown and events.
// Sees only wdts_top ports.
`timescale 1ns/1ps
module wdts_chk #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic io_wr_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire wdts_pkg::wdts_event_t event_o,
	input wire logic running_o,
	input wire logic [7:0] count_o
);
	import wdts_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic [7:0] sel_q;
	wire logic wi = io_wr_i && io_addr_i == WDTS_ADDR_INTERVAL;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) sel_q <= WDTS_EVENT_RST_VAL;
		else if (io_wr_i && io_addr_i == WDTS_ADDR_EVENT) sel_q <= io_wdata_i;
	end
	a_load_count: assert property (wi && io_wdata_i != 8'h00 |-> ##2 count_o == $past(io_wdata_i, 2))
		else $error("load");
	a_zero_stop: assert property (wi && io_wdata_i == 8'h00 |-> ##2 !running_o)
		else $error("stop");
	a_count_step: assert property (running_o && !$past(wi) && !$past(wi, 2) && $changed(count_o)
		|-> count_o == $past(count_o) - 8'h01) else $error("step");
	a_keep_run: assert property (running_o && count_o > 8'h01 && !wi && !$past(wi) |=> running_o)
		else $error("run");
	a_event_map: assert property (event_o != 5'h00 |-> event_o == 5'(5'h10 >> $past(sel_q)))
		else $error("map");
	a_one_pulse: assert property (event_o != 5'h00 |=> event_o == 5'h00)
		else $error("pulse");
	a_fire_idle: assert property (event_o != 5'h00 |-> !running_o)
		else $error("idle");
	a_stay_idle: assert property (!running_o && !wi && !$past(wi) |=> !running_o)
		else $error("stay");
	c_fire: cover property (event_o != 5'h00);
	c_nmi: cover property (event_o.nmi);
	c_refresh: cover property (wi && running_o);
endmodule
bind wdts_top wdts_chk #(.TICK_CYCLES(TICK_CYCLES)) u_wdts_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .event_o(event_o), .running_o(running_o),
	.count_o(count_o));

// ==== tb/wdts_test.sv ====
// Bench for the seconds watchdog, tick of 4 cycles.
// Assumes wdts_top with its bound checker.
`timescale 1ns/1ps
module wdts_test;
	import wdts_pkg::*;
	logic clk_sys_i = 0, nrst_i = 0, io_wr_i = 0, running_o;
	logic [15:0] io_addr_i = 16'h0000;
	logic [7:0] io_wdata_i = 8'h00, count_o;
	wdts_event_t event_o;
	int fails = 0, num_checks = 0, cyc = 0, evs = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	wdts_top #(.TICK_CYCLES(4)) u_wdts_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .io_wr_i(io_wr_i),
		.io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .event_o(event_o), .running_o(running_o), .count_o(count_o));
	task chk(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk_sys_i);
		io_wr_i <= 1'b1;
		io_addr_i <= a;
		io_wdata_i <= d;
		@(posedge clk_sys_i);
		io_wr_i <= 1'b0;
	endtask
	task fire(logic [7:0] c);
		int n;
		wr(WDTS_ADDR_INTERVAL, 8'h01);
		for (n = 0; n < 20 && event_o === 5'h00; n++) @(negedge clk_sys_i);
		chk("event", 8'(5'h10 >> c), 8'(event_o));
		$display("fire %0d done", c);
	endtask
	task refresh_stop();
		wr(WDTS_ADDR_INTERVAL, 8'h03);
		repeat (6) @(negedge clk_sys_i);
		chk("count", 8'h02, count_o);
		chk("running", 8'h01, 8'(running_o));
		wr(WDTS_ADDR_INTERVAL, 8'h05);
		repeat (3) @(negedge clk_sys_i);
		chk("count", 8'h05, count_o);
		wr(WDTS_ADDR_INTERVAL, 8'h00);
		wr(16'h0445, 8'h01);
		repeat (40) @(negedge clk_sys_i);
		chk("events", 8'h06, 8'(evs));
		chk("running", 8'h00, 8'(running_o));
		$display("refresh stop done");
	endtask
	task bad_code();
		wr(WDTS_ADDR_EVENT, 8'h05);
		wr(WDTS_ADDR_INTERVAL, 8'h01);
		repeat (20) @(negedge clk_sys_i);
		chk("events", 8'h06, 8'(evs));
		chk("running", 8'h00, 8'(running_o));
		$display("bad code done");
	endtask
	task end_sim();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge clk_sys_i) begin
		cyc++;
		if (event_o !== 5'h00) evs++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		fire(8'h00);
		for (int i = 4; i >= 0; i--) begin
			wr(WDTS_ADDR_EVENT, 8'(i));
			fire(8'(i));
		end
		refresh_stop();
		bad_code();
		end_sim();
	end
endmodule
